/* File: rhp_pkg.sv */
package rhp_pkg;
  // host port select codes {select_high, select_low}
  localparam logic [1:0] SEL_INDEX = 2'h0;
  localparam logic [1:0] SEL_PALETTE = 2'h1;
  localparam logic [1:0] SEL_CONTROL = 2'h2;
  localparam logic [1:0] SEL_MODE = 2'h3;
  // index values of the indexed control registers
  localparam logic [7:0] IDX_PIXEL_MASK = 8'h04;
  localparam logic [7:0] IDX_COMMAND_ONE = 8'h05;
  localparam logic [7:0] IDX_COMMAND_TWO = 8'h06;
  localparam logic [7:0] IDX_COMMAND_THREE = 8'h07;
  // mode_control field positions
  localparam int MODE_PIPE_RESET_BIT = 0;
  localparam int MODE_DAC_TEN_BIT = 1;
  localparam int MODE_BUS_TEN_BIT = 2;
  localparam int MODE_NORMAL_BIT = 3;
  localparam int MODE_LOAD_CAL_BIT = 5;
  // command register field positions
  localparam int CMD1_CAL_VSYNC_BIT = 0;
  localparam int CMD2_COLOR_LSB = 5;
  localparam logic [2:0] CMD2_TRUE_COLOR_24 = 3'h7;
  localparam int CMD2_PEDESTAL_BIT = 2;
  localparam int CMD2_SYNC_GREEN_BIT = 3;
  localparam int CMD3_DIV8_BIT = 0;
  localparam int CMD3_MUX_2TO1_BIT = 6;
  // reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // palette component order
  localparam logic [1:0] PHASE_RED = 2'h0;
  localparam logic [1:0] PHASE_GREEN = 2'h1;
  localparam logic [1:0] PHASE_BLUE = 2'h2;
  // divided clock output: half periods in clocks
  localparam logic [2:0] DIV8_HALF = 3'h4;
  localparam logic [2:0] DIV4_HALF = 3'h2;
  // three-write sequence tracker
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_FIRST, SEQ_SECOND} rhp_seq_type;
endpackage : rhp_pkg

/* File: rhp_palette_ram.sv */
`timescale 1ns/1ps
module rhp_palette_ram #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 30
) (
  input wire logic i_sys_clk,
  input wire logic i_clk_en,
  input wire logic i_we,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  output logic [DATA_W-1:0] o_rdata
);
  // contents are not cleared by reset, as in any palette memory
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge i_sys_clk) begin
    if (i_clk_en && i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  assign o_rdata = mem[i_addr];
endmodule : rhp_palette_ram

/* File: rhp_host_port.sv */
// Summary of operation
// - both selects high and write: load mode_control; 0FH gives normal 10-bit operation.
// - pipeline reset bit written 1, 0, 1 resets colour pipelines to first mux input.
// - load timing bit written 0, 1, 0 resynchronises pixel load in/out timing.
// - both selects low and write: load index register; 04H reaches pixel mask.
// - select_high only and write: store indexed register; FFH sets all mask bits.
// - index 05H, 06H, 07H decode to command one, two and three.
// - command one value 01H enables calibration on every vertical sync.
// - command two E0H selects 24-bit true colour, no pedestal, no sync.
// - command three 41H: 2:1 mux, divided clock is inverted clock over 8.
// - index 00H points at palette zero; select_low only writes red, green, blue.
// - palette components are 10 bits wide over 256 locations.
// - indexed register read right after a write returns the written value.
// - every register can be reselected and read back after all writes.
`timescale 1ns/1ps
module rhp_host_port #(
  parameter int DATA_W = 10,
  parameter int ADDR_W = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_strobe_n,
  input wire logic i_select_high,
  input wire logic i_select_low,
  input wire logic i_read_not_write,
  input wire logic [DATA_W-1:0] i_data,
  output logic [DATA_W-1:0] o_data,
  output logic o_data_oe,
  output logic [7:0] o_mode_control,
  output logic o_normal_mode,
  output logic o_ten_bit_bus,
  output logic o_ten_bit_dac,
  output logic o_pipeline_reset,
  output logic o_load_resync,
  output logic [7:0] o_pixel_mask,
  output logic o_cal_every_vsync,
  output logic o_true_color_24,
  output logic o_pedestal_on,
  output logic o_sync_on_green,
  output logic o_mux_two_to_one,
  output logic o_divided_clock_out,
  output logic [ADDR_W-1:0] o_palette_pointer
);

  typedef struct packed {
    logic strb_s1;
    logic strb_s2;
    logic [1:0] sel_s1;
    logic [1:0] sel_s2;
    logic rw_s1;
    logic rw_s2;
    logic [DATA_W-1:0] din_s1;
    logic [DATA_W-1:0] din_s2;
    logic busy;
    logic [7:0] mode;
    logic [7:0] index;
    logic [7:0] mask;
    logic [7:0] cmd1;
    logic [7:0] cmd2;
    logic [7:0] cmd3;
    logic [1:0] phase;
    logic [DATA_W-1:0] red;
    logic [DATA_W-1:0] green;
    logic [DATA_W-1:0] rd_data;
    logic oe;
    rhp_pkg::rhp_seq_type pipe_seq;
    rhp_pkg::rhp_seq_type cal_seq;
    logic pipe_pulse;
    logic cal_pulse;
    logic [2:0] div_cnt;
    logic div_out;
  } rhp_state_type;

  rhp_state_type state_reg;
  rhp_state_type state_next;
  logic ram_we;
  logic [3*DATA_W-1:0] ram_wdata;
  logic [3*DATA_W-1:0] ram_rdata;

  // next state of a three-write tracker: first, opposite, first again
  function automatic rhp_pkg::rhp_seq_type seq_step(input rhp_pkg::rhp_seq_type s,
                                                    input logic bit_val,
                                                    input logic first_val);
    rhp_pkg::rhp_seq_type r;
    r = rhp_pkg::SEQ_IDLE;
    if (bit_val == first_val) begin
      r = rhp_pkg::SEQ_FIRST;
    end else if (s == rhp_pkg::SEQ_FIRST || s == rhp_pkg::SEQ_SECOND) begin
      r = (s == rhp_pkg::SEQ_FIRST) ? rhp_pkg::SEQ_SECOND : rhp_pkg::SEQ_IDLE;
    end
    return r;
  endfunction : seq_step

  // the tracker completes when the middle value is followed by the first again
  function automatic logic seq_done(input rhp_pkg::rhp_seq_type s,
                                    input logic bit_val,
                                    input logic first_val);
    return (s == rhp_pkg::SEQ_SECOND) && (bit_val == first_val);
  endfunction : seq_done

  // 8-bit bus values sit in the upper bits of a 10-bit component
  function automatic logic [DATA_W-1:0] to_component(input logic [DATA_W-1:0] d,
                                                     input logic ten_bit);
    logic [DATA_W-1:0] r;
    r = ten_bit ? d : {d[7:0], {(DATA_W-8){1'b0}}};
    return r;
  endfunction : to_component

  function automatic logic [DATA_W-1:0] from_component(input logic [DATA_W-1:0] c,
                                                       input logic ten_bit);
    logic [DATA_W-1:0] r;
    r = ten_bit ? c : {{(DATA_W-8){1'b0}}, c[DATA_W-1:DATA_W-8]};
    return r;
  endfunction : from_component

  always_comb begin
    logic take;
    logic wr;
    logic ten;
    logic [DATA_W-1:0] comp;
    logic [DATA_W-1:0] rd_comp;
    logic [2:0] half;
    take = 1'b0;
    wr = 1'b0;
    ten = 1'b0;
    comp = '0;
    rd_comp = '0;
    half = '0;
    state_next = state_reg;
    ram_we = 1'b0;
    ram_wdata = '0;

    // pins are asynchronous to the system clock
    state_next.strb_s1 = ~i_strobe_n;
    state_next.strb_s2 = state_reg.strb_s1;
    state_next.sel_s1 = {i_select_high, i_select_low};
    state_next.sel_s2 = state_reg.sel_s1;
    state_next.rw_s1 = i_read_not_write;
    state_next.rw_s2 = state_reg.rw_s1;
    state_next.din_s1 = i_data;
    state_next.din_s2 = state_reg.din_s1;

    state_next.pipe_pulse = 1'b0;
    state_next.cal_pulse = 1'b0;

    // one access per strobe, however long the host holds it
    take = state_reg.strb_s2 && !state_reg.busy;
    if (take) begin
      state_next.busy = 1'b1;
    end else if (!state_reg.strb_s2) begin
      state_next.busy = 1'b0;
    end
    state_next.oe = state_reg.strb_s2 && state_reg.rw_s2;

    wr = take && !state_reg.rw_s2;
    ten = state_reg.mode[rhp_pkg::MODE_BUS_TEN_BIT];
    comp = to_component(state_reg.din_s2, ten);

    case (state_reg.phase)
      rhp_pkg::PHASE_RED: rd_comp = ram_rdata[3*DATA_W-1:2*DATA_W];
      rhp_pkg::PHASE_GREEN: rd_comp = ram_rdata[2*DATA_W-1:DATA_W];
      default: rd_comp = ram_rdata[DATA_W-1:0];
    endcase

    if (take) begin
      case (state_reg.sel_s2)
        rhp_pkg::SEL_MODE: begin
          state_next.rd_data = {{(DATA_W-8){1'b0}}, state_reg.mode};
          if (wr) begin
            state_next.mode = state_reg.din_s2[7:0];
            state_next.pipe_seq = seq_step(state_reg.pipe_seq,
                state_reg.din_s2[rhp_pkg::MODE_PIPE_RESET_BIT], 1'b1);
            state_next.pipe_pulse = seq_done(state_reg.pipe_seq,
                state_reg.din_s2[rhp_pkg::MODE_PIPE_RESET_BIT], 1'b1);
            state_next.cal_seq = seq_step(state_reg.cal_seq,
                state_reg.din_s2[rhp_pkg::MODE_LOAD_CAL_BIT], 1'b0);
            state_next.cal_pulse = seq_done(state_reg.cal_seq,
                state_reg.din_s2[rhp_pkg::MODE_LOAD_CAL_BIT], 1'b0);
          end
        end
        rhp_pkg::SEL_INDEX: begin
          state_next.rd_data = {{(DATA_W-8){1'b0}}, state_reg.index};
          if (wr) begin
            // index load restarts the colour order
            state_next.index = state_reg.din_s2[7:0];
            state_next.phase = rhp_pkg::PHASE_RED;
          end
        end
        rhp_pkg::SEL_CONTROL: begin
          case (state_reg.index)
            rhp_pkg::IDX_PIXEL_MASK: begin
              state_next.rd_data = {{(DATA_W-8){1'b0}}, state_reg.mask};
            end
            rhp_pkg::IDX_COMMAND_ONE: begin
              state_next.rd_data = {{(DATA_W-8){1'b0}}, state_reg.cmd1};
            end
            rhp_pkg::IDX_COMMAND_TWO: begin
              state_next.rd_data = {{(DATA_W-8){1'b0}}, state_reg.cmd2};
            end
            rhp_pkg::IDX_COMMAND_THREE: begin
              state_next.rd_data = {{(DATA_W-8){1'b0}}, state_reg.cmd3};
            end
            default: begin
              state_next.rd_data = '0;
            end
          endcase
          if (wr) begin
            case (state_reg.index)
              rhp_pkg::IDX_PIXEL_MASK: state_next.mask = state_reg.din_s2[7:0];
              rhp_pkg::IDX_COMMAND_ONE: state_next.cmd1 = state_reg.din_s2[7:0];
              rhp_pkg::IDX_COMMAND_TWO: state_next.cmd2 = state_reg.din_s2[7:0];
              rhp_pkg::IDX_COMMAND_THREE: state_next.cmd3 = state_reg.din_s2[7:0];
              default: begin
              end
            endcase
          end
        end
        default: begin
          // palette access in red, green, blue order
          state_next.rd_data = from_component(rd_comp, ten);
          case (state_reg.phase)
            rhp_pkg::PHASE_RED: begin
              state_next.phase = rhp_pkg::PHASE_GREEN;
              if (wr) begin
                state_next.red = comp;
              end
            end
            rhp_pkg::PHASE_GREEN: begin
              state_next.phase = rhp_pkg::PHASE_BLUE;
              if (wr) begin
                state_next.green = comp;
              end
            end
            default: begin
              // full 30-bit location written at once
              ram_we = wr;
              ram_wdata = {state_reg.red, state_reg.green, comp};
              state_next.phase = rhp_pkg::PHASE_RED;
              state_next.index = state_reg.index + 8'h01;
            end
          endcase
        end
      endcase
      if (wr) begin
        state_next.rd_data = state_reg.rd_data;
      end
    end

    // divided clock, inverted phase starts high
    half = state_reg.cmd3[rhp_pkg::CMD3_DIV8_BIT] ? rhp_pkg::DIV8_HALF : rhp_pkg::DIV4_HALF;
    if (state_reg.div_cnt >= half - 3'h1) begin
      state_next.div_cnt = '0;
      state_next.div_out = ~state_reg.div_out;
    end else begin
      state_next.div_cnt = state_reg.div_cnt + 3'h1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg <= '0;
      state_reg.mode <= rhp_pkg::MODE_RESET;
      state_reg.index <= rhp_pkg::INDEX_RESET;
      state_reg.mask <= rhp_pkg::CTRL_RESET;
      state_reg.cmd1 <= rhp_pkg::CTRL_RESET;
      state_reg.cmd2 <= rhp_pkg::CTRL_RESET;
      state_reg.cmd3 <= rhp_pkg::CTRL_RESET;
      state_reg.phase <= rhp_pkg::PHASE_RED;
      state_reg.pipe_seq <= rhp_pkg::SEQ_IDLE;
      state_reg.cal_seq <= rhp_pkg::SEQ_IDLE;
      state_reg.div_out <= 1'b1;
    end else if (i_clk_en) begin
      state_reg <= state_next;
    end
  end

  // address comes from the index, so reads see the current location
  rhp_palette_ram #(
    .ADDR_W(ADDR_W),
    .DATA_W(3*DATA_W)
  ) u_palette (
    .i_sys_clk(i_sys_clk),
    .i_clk_en(i_clk_en),
    .i_we(ram_we),
    .i_addr(state_reg.index),
    .i_wdata(ram_wdata),
    .o_rdata(ram_rdata)
  );

  assign o_data = state_reg.rd_data;
  assign o_data_oe = state_reg.oe;
  assign o_mode_control = state_reg.mode;
  assign o_normal_mode = state_reg.mode[rhp_pkg::MODE_NORMAL_BIT];
  assign o_ten_bit_bus = state_reg.mode[rhp_pkg::MODE_BUS_TEN_BIT];
  assign o_ten_bit_dac = state_reg.mode[rhp_pkg::MODE_DAC_TEN_BIT];
  assign o_pipeline_reset = state_reg.pipe_pulse;
  assign o_load_resync = state_reg.cal_pulse;
  assign o_pixel_mask = state_reg.mask;
  assign o_cal_every_vsync = state_reg.cmd1[rhp_pkg::CMD1_CAL_VSYNC_BIT];
  assign o_true_color_24 = state_reg.cmd2[rhp_pkg::CMD2_COLOR_LSB+:3] == rhp_pkg::CMD2_TRUE_COLOR_24;
  assign o_pedestal_on = state_reg.cmd2[rhp_pkg::CMD2_PEDESTAL_BIT];
  assign o_sync_on_green = state_reg.cmd2[rhp_pkg::CMD2_SYNC_GREEN_BIT];
  assign o_mux_two_to_one = state_reg.cmd3[rhp_pkg::CMD3_MUX_2TO1_BIT];
  assign o_divided_clock_out = state_reg.div_out;
  assign o_palette_pointer = state_reg.index;
endmodule : rhp_host_port

/* File: rhp_host_port_assertions.sv */
`timescale 1ns/1ps
module rhp_host_port_checker #(
  parameter int DATA_W = 10,
  parameter int ADDR_W = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_strobe_n,
  input wire logic i_select_high,
  input wire logic i_select_low,
  input wire logic i_read_not_write,
  input wire logic [DATA_W-1:0] o_data,
  input wire logic o_data_oe,
  input wire logic [7:0] o_mode_control,
  input wire logic o_normal_mode,
  input wire logic o_ten_bit_bus,
  input wire logic o_ten_bit_dac,
  input wire logic o_pipeline_reset,
  input wire logic o_load_resync,
  input wire logic [7:0] o_pixel_mask,
  input wire logic o_divided_clock_out,
  input wire logic [ADDR_W-1:0] o_palette_pointer
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  property p_mode_fields;
    o_normal_mode == o_mode_control[3] && o_ten_bit_bus == o_mode_control[2]
      && o_ten_bit_dac == o_mode_control[1];
  endproperty
  a_mode_fields: assert property (p_mode_fields)
    else $error("mode fields differ from mode register");
  property p_pipe_pulse;
    o_pipeline_reset |=> !o_pipeline_reset;
  endproperty
  a_pipe_pulse: assert property (p_pipe_pulse)
    else $error("pipeline reset longer than one cycle");
  property p_resync_pulse;
    o_load_resync |=> !o_load_resync;
  endproperty
  a_resync_pulse: assert property (p_resync_pulse)
    else $error("load resync longer than one cycle");
  property p_oe_cause;
    $rose(o_data_oe) |-> $past(i_read_not_write, 2) && !$past(i_strobe_n, 2);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("data drive without a read strobe");
  property p_oe_release;
    i_strobe_n [*5] |-> !o_data_oe;
  endproperty
  a_oe_release: assert property (p_oe_release)
    else $error("data drive held after strobe release");
  property p_data_hold;
    $changed(o_data) |-> o_data_oe;
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("read data changed outside a read");
  property p_mask_write;
    $changed(o_pixel_mask) |->
      $past(i_select_high && !i_select_low && !i_read_not_write, 3);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("pixel mask changed without control write");
  property p_ptr_access;
    $changed(o_palette_pointer) |-> !$past(i_strobe_n, 3);
  endproperty
  a_ptr_access: assert property (p_ptr_access)
    else $error("pointer moved without an access");
  property p_div_half;
    $changed(o_divided_clock_out) |=> $stable(o_divided_clock_out);
  endproperty
  a_div_half: assert property (p_div_half)
    else $error("divided clock half period too short");
endmodule : rhp_host_port_checker

bind rhp_host_port rhp_host_port_checker #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_chk (.*);

/* File: rhp_host_model.sv */
`timescale 1ns/1ps
module rhp_host_model (
  input wire logic i_sys_clk,
  input wire logic [9:0] i_data,
  output logic o_strobe_n,
  output logic o_select_high,
  output logic o_select_low,
  output logic o_read_not_write,
  output logic [9:0] o_data
);
  initial begin
    o_strobe_n = 1'b1;
    {o_select_high, o_select_low, o_read_not_write} = 3'h0;
    o_data = 10'h000;
  end
  // select and direction held across strobe
  task automatic access(input logic [1:0] sel, input logic rnw, input logic [9:0] wd,
                        output logic [9:0] rd);
    @(posedge i_sys_clk);
    {o_select_high, o_select_low} <= sel;
    o_read_not_write <= rnw;
    // released bus shows the inverse, not a stale copy
    o_data <= rnw ? ~o_data : wd;
    repeat (3) @(posedge i_sys_clk);
    o_strobe_n <= 1'b0;
    repeat (7) @(posedge i_sys_clk);
    rd = i_data;
    o_strobe_n <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
  endtask : access
endmodule : rhp_host_model

/* File: rhp_tb.sv */
`timescale 1ns/1ps
module tb;
  logic i_sys_clk, i_reset, i_strobe_n, i_select_high, i_select_low, i_read_not_write;
  logic i_clk_en = 1'b1;
  logic [9:0] i_data, o_data, rd;
  logic [7:0] o_mode_control, o_pixel_mask, o_palette_pointer;
  logic o_data_oe, o_normal_mode, o_ten_bit_bus, o_ten_bit_dac, o_pipeline_reset;
  logic o_load_resync, o_cal_every_vsync, o_true_color_24, o_pedestal_on;
  logic o_sync_on_green, o_mux_two_to_one, o_divided_clock_out;
  int err_count = 0, cmp_count = 0, pipe_n = 0, sync_n = 0, cycles = 0, oe_n = 0;
  logic [9:0] nar [3] = '{10'h3A5, 10'h15A, 10'h2C3};
  logic [9:0] pal [6] = '{10'h000, 10'h155, 10'h3FF, 10'h2AA, 10'h001, 10'h3FE};
  logic [9:0] regv [4] = '{10'h0FF, 10'h001, 10'h0E0, 10'h040};
  rhp_host_port u_rhp_host_port (.*);
  rhp_host_model u_rhp_host_model (.i_sys_clk(i_sys_clk), .i_data(o_data),
    .o_strobe_n(i_strobe_n), .o_select_high(i_select_high), .o_select_low(i_select_low),
    .o_read_not_write(i_read_not_write), .o_data(i_data));
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  // the ceiling is nearly four times the expected run
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (o_pipeline_reset === 1'b1) pipe_n <= pipe_n + 1;
    if (o_load_resync === 1'b1) sync_n <= sync_n + 1;
    if (o_data_oe === 1'b1) oe_n <= oe_n + 1;
    if (cycles == 3000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic complete_run;
    if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] s, input logic [9:0] d);
    u_rhp_host_model.access(s, 1'b0, d, rd);
  endtask : wr
  task automatic rb(input logic [1:0] s);
    u_rhp_host_model.access(s, 1'b1, 10'h000, rd);
  endtask : rb
  task automatic per(input logic [9:0] e);
    realtime t0;
    @(posedge o_divided_clock_out);
    t0 = $realtime;
    @(posedge o_divided_clock_out);
    chk(10'(int'(($realtime - t0) / 20.0)), e);
  endtask : per
  task automatic t_mode;
    wr(rhp_pkg::SEL_MODE, 10'h00F);
    wr(rhp_pkg::SEL_MODE, 10'h00E);
    wr(rhp_pkg::SEL_MODE, 10'h00F);
    wr(rhp_pkg::SEL_MODE, 10'h02F);
    wr(rhp_pkg::SEL_MODE, 10'h00F);
    chk(10'(pipe_n), 10'h001);
    chk(10'(sync_n), 10'h001);
    chk({7'h00, o_normal_mode, o_ten_bit_bus, o_ten_bit_dac}, 10'h007);
    chk({2'h0, o_mode_control}, 10'h00F);
    chk({9'h000, oe_n != 0}, 10'h000);
    rb(rhp_pkg::SEL_MODE);
    chk(rd, 10'h00F);
    chk({9'h000, oe_n != 0}, 10'h001);
    chk({9'h000, o_data_oe}, 10'h000);
  endtask : t_mode
  task automatic t_ctrl;
    wr(rhp_pkg::SEL_INDEX, 10'h004);
    chk({2'h0, o_palette_pointer}, 10'h004);
    wr(rhp_pkg::SEL_CONTROL, 10'h0FF);
    chk({2'h0, o_pixel_mask}, 10'h0FF);
    for (int i = 1; i < 4; i++) begin
      wr(rhp_pkg::SEL_INDEX, 10'(4 + i));
      wr(rhp_pkg::SEL_CONTROL, i == 3 ? 10'h041 : regv[i]);
      rb(rhp_pkg::SEL_CONTROL);
      chk(rd, i == 3 ? 10'h041 : regv[i]);
    end
    chk({7'h00, o_cal_every_vsync, o_mux_two_to_one, o_true_color_24}, 10'h007);
    chk({8'h00, o_pedestal_on, o_sync_on_green}, 10'h000);
    per(10'h008);
    wr(rhp_pkg::SEL_CONTROL, 10'h040);
    chk({9'h000, o_mux_two_to_one}, 10'h001);
    per(10'h004);
    wr(rhp_pkg::SEL_INDEX, 10'h008);
    wr(rhp_pkg::SEL_CONTROL, 10'h055);
    rb(rhp_pkg::SEL_CONTROL);
    chk(rd, 10'h000);
  endtask : t_ctrl
  task automatic t_pal;
    wr(rhp_pkg::SEL_INDEX, 10'h000);
    for (int i = 0; i < 6; i++) wr(rhp_pkg::SEL_PALETTE, pal[i]);
    chk({2'h0, o_palette_pointer}, 10'h002);
    wr(rhp_pkg::SEL_INDEX, 10'h000);
    for (int i = 0; i < 6; i++) begin
      rb(rhp_pkg::SEL_PALETTE);
      chk(rd, pal[i]);
    end
  endtask : t_pal
  task automatic t_verify;
    for (int i = 0; i < 4; i++) begin
      wr(rhp_pkg::SEL_INDEX, 10'(4 + i));
      rb(rhp_pkg::SEL_CONTROL);
      chk(rd, regv[i]);
    end
  endtask : t_verify
  // 8-bit bus: only bits 7:0 count, and the pointer wraps past the last location
  task automatic t_narrow;
    wr(rhp_pkg::SEL_MODE, 10'h00B);
    chk({9'h000, o_ten_bit_bus}, 10'h000);
    wr(rhp_pkg::SEL_INDEX, 10'h0FF);
    for (int i = 0; i < 3; i++) wr(rhp_pkg::SEL_PALETTE, nar[i]);
    chk({2'h0, o_palette_pointer}, 10'h000);
    wr(rhp_pkg::SEL_INDEX, 10'h0FF);
    for (int i = 0; i < 3; i++) begin
      rb(rhp_pkg::SEL_PALETTE);
      chk(rd, {2'h0, nar[i][7:0]});
    end
  endtask : t_narrow
  initial begin
    i_reset = 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    t_mode();
    t_ctrl();
    t_pal();
    t_verify();
    t_narrow();
    complete_run();
  end
endmodule : tb
